// ---- uasw_pkg.sv ----
// What this block does
// R1: characters carry eight or nine data bits, chosen by configuration.
// R2: parity may be even, odd, mark, space or none.
// R3: frames end with one or two stop bits, chosen by configuration.
// R4: both directions are timed from a 16-bit programmable baud prescaler.
// R5: receiver flags parity, framing, noise and receive overrun errors.
// R6: with address detect on, a character whose last data bit is one interrupts.
// R7: four-entry receive FIFO; one character held ahead of the transmit shifter.
// R8: interrupt on transmit empty, transmit idle, receive full, overrun, address detect.
// R9: activity on the receive or shared pin can wake the device.
// R10: transmitter and receiver have independent enables.
// R11: enabled directions drive tx pin, take receive pin as input, pull-ups off.
// R12: cleared enables float the pin; pull-up then left to general I/O control.
// R13: single-wire select puts the port in half duplex on one shared pin.
// R14: half duplex: shared pin receives when receiver enabled, else transmits.
// R15: with both enables set in half duplex, receive wins.
// R16: in half duplex the tx pin may also carry the transmit stream.
// R17: written character moves to a hidden shifter and leaves LSB first.
// R18: received bits shift in LSB first, then move to the readable buffer.
// R19: one data address: writes transmit, reads return received data.
// R20: start bit low, stop bits high, line idles high.
// R21: port disable flushes, resets baud count, clears enables and flags.
// R22: character length select zero means 8 bits, one means 9 bits.
// R23: receive flag sets at FIFO trigger level; interrupts when enabled.
// R24: setting transmitter enable shows the transmit register empty.
package uasw_pkg;
    // ======================================================================
    // register map
    localparam logic [7:0] UASW_OFF_STATUS = 8'h00;
    localparam logic [7:0] UASW_OFF_CTRL1 = 8'h04;
    localparam logic [7:0] UASW_OFF_CTRL2 = 8'h08;
    localparam logic [7:0] UASW_OFF_CTRL3 = 8'h0c;
    localparam logic [7:0] UASW_OFF_DATA = 8'h10;
    localparam logic [7:0] UASW_OFF_BDH = 8'h14;
    localparam logic [7:0] UASW_OFF_BDL = 8'h18;
    localparam logic [7:0] UASW_OFF_FCR = 8'h1c;
    localparam logic [7:0] UASW_OFF_CNT = 8'h20;
    // ======================================================================
    // fields of serial_control_one
    localparam int UASW_C1_PORT_EN = 7;
    localparam int UASW_C1_CHLEN = 6;
    localparam int UASW_C1_PAR_EN = 5;
    localparam int UASW_C1_PT_HI = 4;
    localparam int UASW_C1_PT_LO = 3;
    localparam int UASW_C1_BREAK = 2;
    localparam int UASW_C1_TX9 = 0;
    // serial_control_three
    localparam int UASW_C3_SINGLE = 0;
    localparam int UASW_C3_TXCOPY = 1;
    // fifo_and_mode_control
    localparam int UASW_FCR_W = 6;
    localparam logic [7:0] UASW_RST8 = 8'h00;
    // ======================================================================
    // framing and timing
    localparam logic [3:0] UASW_OS_S1 = 4'h7;
    localparam logic [3:0] UASW_OS_S2 = 4'h8;
    localparam logic [3:0] UASW_OS_DEC = 4'h9;
    localparam logic [3:0] UASW_OS_LAST = 4'hf;
    localparam logic [3:0] UASW_LEN8 = 4'h8;
    localparam logic [3:0] UASW_LEN9 = 4'h9;
    localparam logic [2:0] UASW_DEPTH = 3'h4;
    // ======================================================================
    typedef enum logic [1:0] {
        UASW_PAR_EVEN = 2'h0,
        UASW_PAR_ODD = 2'h1,
        UASW_PAR_MARK = 2'h2,
        UASW_PAR_SPACE = 2'h3
    } uasw_par_e;
    typedef enum logic [1:0] {
        UASW_RX_IDLE = 2'b00,
        UASW_RX_START = 2'b01,
        UASW_RX_BITS = 2'b11
    } uasw_rx_e;
    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic stop2;
        logic addr_det;
        logic wake_en;
        logic rx_ie;
        logic txidle_ie;
        logic txempty_ie;
    } uasw_ctrl2_s;
    typedef struct packed {
        logic parity_error_flag;
        logic noise;
        logic framing_error_flag;
        logic [8:0] data;
    } uasw_rxres_s;
endpackage

// ---- uasw_top.sv ----
`timescale 1ns/100ps
module uasw_top import uasw_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    // shared receive/transmit pin
    input wire logic i_rxtx_pin,
    output logic o_rxtx_pin,
    output logic o_rxtx_oe,
    output logic o_rxtx_pullup_off,
    // dedicated transmit pin
    output logic o_tx_pin,
    output logic o_tx_oe,
    output logic o_tx_pullup_off,
    // system
    output logic o_irq,
    output logic o_wake
);
    // ======================================================================
    // helpers
    function automatic logic par_bit(input logic [8:0] d, input logic nine,
                                     input logic [1:0] pt);
        logic x;
        x = ^d[7:0] ^ (nine & d[8]);
        case (pt)
            UASW_PAR_EVEN: par_bit = x;
            UASW_PAR_ODD: par_bit = ~x;
            UASW_PAR_MARK: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == UASW_OFF_STATUS) || (a == UASW_OFF_CTRL1) ||
                 (a == UASW_OFF_CTRL2) || (a == UASW_OFF_CTRL3) ||
                 (a == UASW_OFF_DATA) || (a == UASW_OFF_BDH) ||
                 (a == UASW_OFF_BDL) || (a == UASW_OFF_FCR) ||
                 (a == UASW_OFF_CNT);
    endfunction

    // ======================================================================
    // declarations
    logic [7:0] ctrl1_ff;
    uasw_ctrl2_s ctrl2_ff;
    logic [1:0] ctrl3_ff;
    logic [7:0] bdh_ff;
    logic [7:0] bdl_ff;
    logic [UASW_FCR_W-1:0] fcr_ff;
    logic [31:0] prdata_ff;
    logic [15:0] baud_cnt_ff;
    logic rx_meta_ff;
    logic rx_sync_ff;
    logic [8:0] tx_buf_ff;
    logic tx_full_ff;
    logic [12:0] tx_sh_ff;
    logic [3:0] tx_left_ff;
    logic [3:0] tx_os_ff;
    logic tx_out_ff;
    uasw_rx_e rx_st_ff;
    logic [3:0] rx_os_ff;
    logic [3:0] rx_idx_ff;
    logic [8:0] rx_sh_ff;
    logic rx_parbit_ff;
    logic rx_s1_ff;
    logic rx_s2_ff;
    logic rx_noise_ff;
    logic [8:0] fifo_ff [UASW_DEPTH];
    logic [1:0] wr_ptr_ff;
    logic [1:0] rd_ptr_ff;
    logic [2:0] cnt_ff;
    logic parity_error_flag_ff;
    logic nf_ff;
    logic framing_error_flag_ff;
    logic overrun_flag_ff;
    logic addr_hit_ff;
    logic status_seen_ff;

    logic wr;
    logic rd;
    logic port_en;
    logic nine;
    logic [3:0] nbits;
    logic tx_run;
    logic rx_run;
    logic os_tick;
    logic tx_busy;
    logic tx_go;
    logic tx_line;
    logic [12:0] tx_frame;
    logic [3:0] tx_len;
    logic maj;
    logic noisy;
    logic [3:0] stop_idx;
    logic rx_done;
    uasw_rxres_s rx_res;
    logic push;
    logic pop;
    logic data_acc;
    logic err_clr;
    logic [8:0] head;
    logic receive_data_available;
    logic transmit_register_empty;
    logic transmitter_idle_flag;
    logic [7:0] status;
    logic [31:0] rd_val;

    // ======================================================================
    // bus slave: zero wait states, read data sampled in setup cycle
    assign wr = i_psel & i_penable & i_pwrite;
    assign rd = i_psel & i_penable & ~i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped(i_paddr);
    assign o_prdata = prdata_ff;
    assign port_en = ctrl1_ff[UASW_C1_PORT_EN];
    assign nine = ctrl1_ff[UASW_C1_CHLEN];
    assign nbits = nine ? UASW_LEN9 : UASW_LEN8; // see R1 see R22
    assign data_acc = i_psel & i_penable & (i_paddr == UASW_OFF_DATA);

    always_comb begin
        case (i_paddr)
            UASW_OFF_STATUS: rd_val = {24'h0, status};
            UASW_OFF_CTRL1: rd_val = {24'h0, ctrl1_ff[7:2], head[8], 1'b0};
            UASW_OFF_CTRL2: rd_val = {24'h0, ctrl2_ff};
            UASW_OFF_CTRL3: rd_val = {30'h0, ctrl3_ff};
            UASW_OFF_DATA: rd_val = {24'h0, head[7:0]}; // see R19
            UASW_OFF_BDH: rd_val = {24'h0, bdh_ff};
            UASW_OFF_BDL: rd_val = {24'h0, bdl_ff};
            UASW_OFF_FCR: rd_val = {26'h0, fcr_ff};
            UASW_OFF_CNT: rd_val = {29'h0, cnt_ff};
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prdata_ff <= 32'h0;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            prdata_ff <= rd_val;
        end
    end

    // ======================================================================
    // control registers; disable clears enables and break
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl1_ff <= UASW_RST8;
            ctrl2_ff <= '0;
            ctrl3_ff <= 2'h0;
            bdh_ff <= UASW_RST8;
            bdl_ff <= UASW_RST8;
            fcr_ff <= '0;
        end else begin
            if (wr && i_paddr == UASW_OFF_CTRL1) begin
                ctrl1_ff <= i_pwdata[7:0];
            end else if (!port_en) begin
                ctrl1_ff[UASW_C1_BREAK] <= 1'b0; // see R21
            end
            if (wr && i_paddr == UASW_OFF_CTRL2) begin
                ctrl2_ff <= i_pwdata[7:0]; // see R10
            end else if (!port_en) begin
                ctrl2_ff.tx_en <= 1'b0; // see R21
                ctrl2_ff.rx_en <= 1'b0;
            end
            if (wr && i_paddr == UASW_OFF_CTRL3) begin
                ctrl3_ff <= i_pwdata[1:0]; // see R13
            end
            if (wr && i_paddr == UASW_OFF_BDH) begin
                bdh_ff <= i_pwdata[7:0];
            end
            if (wr && i_paddr == UASW_OFF_BDL) begin
                bdl_ff <= i_pwdata[7:0];
            end
            if (wr && i_paddr == UASW_OFF_FCR) begin
                fcr_ff <= i_pwdata[UASW_FCR_W-1:0];
            end
        end
    end

    // ======================================================================
    // baud prescaler: one oversample tick every divisor+1 clocks, 16 per bit
    assign os_tick = port_en && (baud_cnt_ff == {bdh_ff, bdl_ff}); // see R4

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            baud_cnt_ff <= 16'h0;
        end else if (!port_en || os_tick) begin
            baud_cnt_ff <= 16'h0; // see R21
        end else begin
            baud_cnt_ff <= baud_cnt_ff + 16'h1;
        end
    end

    // ======================================================================
    // transmitter: in half duplex the receiver takes the pin first
    assign tx_run = port_en & ctrl2_ff.tx_en &
                    ~(ctrl3_ff[UASW_C3_SINGLE] & ctrl2_ff.rx_en); // see R15
    assign tx_busy = (tx_left_ff != 4'h0);
    assign tx_go = tx_run & tx_full_ff & ~tx_busy & ~ctrl1_ff[UASW_C1_BREAK];

    always_comb begin
        tx_frame = '1; // see R20
        tx_frame[0] = 1'b0;
        tx_frame[8:1] = tx_buf_ff[7:0]; // see R17
        tx_len = UASW_LEN9;
        if (nine) begin
            tx_frame[9] = tx_buf_ff[8];
            tx_len = UASW_LEN9 + 4'h1;
        end
        if (ctrl1_ff[UASW_C1_PAR_EN]) begin
            tx_frame[tx_len] = par_bit(tx_buf_ff, nine,
                ctrl1_ff[UASW_C1_PT_HI:UASW_C1_PT_LO]); // see R2
            tx_len = tx_len + 4'h1;
        end
        tx_len = tx_len + 4'h1 + {3'h0, ctrl2_ff.stop2}; // see R3
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_buf_ff <= 9'h0;
            tx_full_ff <= 1'b0;
        end else if (!port_en) begin
            tx_full_ff <= 1'b0; // see R21
        end else if (wr && i_paddr == UASW_OFF_DATA) begin
            tx_buf_ff <= {ctrl1_ff[UASW_C1_TX9], i_pwdata[7:0]}; // see R19
            tx_full_ff <= 1'b1; // see R7
        end else if (tx_go) begin
            tx_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_sh_ff <= '1;
            tx_left_ff <= 4'h0;
            tx_os_ff <= 4'h0;
        end else if (!port_en) begin
            tx_left_ff <= 4'h0;
            tx_os_ff <= 4'h0;
        end else if (tx_go) begin
            tx_sh_ff <= tx_frame;
            tx_left_ff <= tx_len;
            tx_os_ff <= 4'h0;
        end else if (os_tick && tx_busy) begin
            tx_os_ff <= tx_os_ff + 4'h1;
            if (tx_os_ff == UASW_OS_LAST) begin
                tx_sh_ff <= {1'b1, tx_sh_ff[12:1]}; // see R17
                tx_left_ff <= tx_left_ff - 4'h1;
            end
        end
    end

    // break holds the line low; idle is high
    assign tx_line = ctrl1_ff[UASW_C1_BREAK] ? 1'b0 :
                     (tx_busy ? tx_sh_ff[0] : 1'b1); // see R20

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_out_ff <= 1'b1;
        end else begin
            tx_out_ff <= tx_line;
        end
    end

    // ======================================================================
    // receiver: pin synchroniser, three-sample vote mid bit
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
        end else begin
            rx_meta_ff <= i_rxtx_pin;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    assign rx_run = port_en & ctrl2_ff.rx_en; // see R14
    assign maj = (rx_s1_ff & rx_s2_ff) | (rx_s1_ff & rx_sync_ff) |
                 (rx_s2_ff & rx_sync_ff);
    assign noisy = ~((rx_s1_ff == rx_s2_ff) && (rx_s2_ff == rx_sync_ff)); // see R5
    assign stop_idx = nbits + {3'h0, ctrl1_ff[UASW_C1_PAR_EN]};
    assign rx_done = (rx_st_ff == UASW_RX_BITS) && os_tick &&
                     (rx_os_ff == UASW_OS_DEC) && (rx_idx_ff == stop_idx);
    assign rx_res.data = rx_sh_ff;
    assign rx_res.framing_error_flag = ~maj; // see R20
    assign rx_res.noise = rx_noise_ff | noisy;
    assign rx_res.parity_error_flag = ctrl1_ff[UASW_C1_PAR_EN] &
        (rx_parbit_ff != par_bit(rx_sh_ff, nine,
                                 ctrl1_ff[UASW_C1_PT_HI:UASW_C1_PT_LO]));

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_st_ff <= UASW_RX_IDLE;
            rx_os_ff <= 4'h0;
            rx_idx_ff <= 4'h0;
            rx_sh_ff <= 9'h0;
            rx_parbit_ff <= 1'b0;
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
            rx_noise_ff <= 1'b0;
        end else if (!rx_run) begin
            rx_st_ff <= UASW_RX_IDLE; // see R21
        end else begin
            case (rx_st_ff)
                UASW_RX_IDLE: begin
                    if (!rx_sync_ff) begin
                        rx_st_ff <= UASW_RX_START;
                        rx_os_ff <= 4'h0;
                        rx_idx_ff <= 4'h0;
                        rx_sh_ff <= 9'h0;
                        rx_noise_ff <= 1'b0;
                    end
                end
                UASW_RX_START, UASW_RX_BITS: begin
                    if (os_tick) begin
                        rx_os_ff <= rx_os_ff + 4'h1;
                        if (rx_os_ff == UASW_OS_S1) begin
                            rx_s1_ff <= rx_sync_ff;
                        end
                        if (rx_os_ff == UASW_OS_S2) begin
                            rx_s2_ff <= rx_sync_ff;
                        end
                        if (rx_os_ff == UASW_OS_DEC) begin
                            rx_noise_ff <= rx_noise_ff | noisy;
                            if (rx_st_ff == UASW_RX_START) begin
                                rx_st_ff <= maj ? UASW_RX_IDLE : UASW_RX_BITS;
                            end else if (rx_idx_ff < nbits) begin
                                rx_sh_ff[rx_idx_ff] <= maj; // see R18
                                rx_idx_ff <= rx_idx_ff + 4'h1;
                            end else if (rx_idx_ff < stop_idx) begin
                                rx_parbit_ff <= maj;
                                rx_idx_ff <= rx_idx_ff + 4'h1;
                            end else begin
                                rx_st_ff <= UASW_RX_IDLE;
                            end
                        end
                    end
                end
                default: rx_st_ff <= UASW_RX_IDLE;
            endcase
        end
    end

    // ======================================================================
    // receive fifo; an overrun blocks further pushes until cleared
    assign push = rx_done & (cnt_ff != UASW_DEPTH) & ~overrun_flag_ff; // see R7
    assign pop = rd & (i_paddr == UASW_OFF_DATA) & (cnt_ff != 3'h0);
    assign head = fifo_ff[rd_ptr_ff];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr_ff <= 2'h0;
            rd_ptr_ff <= 2'h0;
            cnt_ff <= 3'h0;
        end else if (!port_en) begin
            wr_ptr_ff <= 2'h0; // see R21
            rd_ptr_ff <= 2'h0;
            cnt_ff <= 3'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 2'h1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 2'h1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 3'h1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 3'h1;
            end
        end
    end

    for (genvar g = 0; g < UASW_DEPTH; g++) begin : g_fifo
        always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                fifo_ff[g] <= 9'h0;
            end else if (push && wr_ptr_ff == 2'(g)) begin
                fifo_ff[g] <= rx_res.data; // see R18
            end
        end
    end

    // ======================================================================
    // error flags: status read then data access clears; a new set wins
    assign err_clr = status_seen_ff & data_acc;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_seen_ff <= 1'b0;
        end else if (rd && i_paddr == UASW_OFF_STATUS) begin
            status_seen_ff <= 1'b1;
        end else if (data_acc || !port_en) begin
            status_seen_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            parity_error_flag_ff <= 1'b0;
            nf_ff <= 1'b0;
            framing_error_flag_ff <= 1'b0;
            overrun_flag_ff <= 1'b0;
            addr_hit_ff <= 1'b0;
        end else if (!port_en) begin
            parity_error_flag_ff <= 1'b0; // see R21
            nf_ff <= 1'b0;
            framing_error_flag_ff <= 1'b0;
            overrun_flag_ff <= 1'b0;
            addr_hit_ff <= 1'b0;
        end else begin
            parity_error_flag_ff <= (push & rx_res.parity_error_flag) | (parity_error_flag_ff & ~err_clr); // see R5
            nf_ff <= (push & rx_res.noise) | (nf_ff & ~err_clr);
            framing_error_flag_ff <= (push & rx_res.framing_error_flag) | (framing_error_flag_ff & ~err_clr);
            overrun_flag_ff <= (rx_done & ~push) | (overrun_flag_ff & ~err_clr);
            addr_hit_ff <= (push & ctrl2_ff.addr_det &
                            (nine ? rx_res.data[8] : rx_res.data[7])) |
                           (addr_hit_ff & ~pop); // see R6
        end
    end

    // ======================================================================
    // status, interrupt, wake
    assign receive_data_available = (cnt_ff != 3'h0) &&
                  (cnt_ff >= {1'b0, fcr_ff[1:0]} + 3'h1); // see R23
    assign transmit_register_empty = ~tx_full_ff; // see R24
    assign transmitter_idle_flag = transmit_register_empty & ~tx_busy & ~ctrl1_ff[UASW_C1_BREAK];
    assign status = {parity_error_flag_ff, nf_ff, framing_error_flag_ff, overrun_flag_ff,
                     rx_st_ff == UASW_RX_IDLE, receive_data_available, transmitter_idle_flag, transmit_register_empty};

    assign o_irq = port_en & ((ctrl2_ff.rx_ie & (receive_data_available | overrun_flag_ff)) |
                              (ctrl2_ff.txidle_ie & transmitter_idle_flag) |
                              (ctrl2_ff.txempty_ie & transmit_register_empty) |
                              addr_hit_ff); // see R8
    assign o_wake = port_en & ctrl2_ff.wake_en & ~rx_sync_ff; // see R9

    // ======================================================================
    // pins: output enables follow the enables, floating otherwise
    assign o_tx_pin = tx_out_ff;
    assign o_rxtx_pin = tx_out_ff;
    always_comb begin
        if (ctrl3_ff[UASW_C3_SINGLE]) begin
            o_rxtx_oe = tx_run; // see R14
            o_tx_oe = tx_run & ctrl3_ff[UASW_C3_TXCOPY]; // see R16
            o_rxtx_pullup_off = rx_run | tx_run;
        end else begin
            o_rxtx_oe = 1'b0; // see R11
            o_tx_oe = tx_run; // see R12
            o_rxtx_pullup_off = rx_run;
        end
        o_tx_pullup_off = o_tx_oe;
    end
endmodule

// ---- uasw_checker.sv ----
`timescale 1ns/100ps
module uasw_checker (
    // clock, reset, apb
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // pins
    input wire logic i_rxtx_pin,
    input wire logic o_rxtx_oe,
    input wire logic o_rxtx_pullup_off,
    input wire logic o_tx_pin,
    input wire logic o_tx_oe,
    input wire logic o_tx_pullup_off,
    input wire logic o_wake
);
    // ==========
    // properties
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_rd_setup;
        i_psel && !i_penable && !i_pwrite;
    endsequence
    a_pready_high: assert property (o_pready) else $error("pready low");
    a_slverr_unmapped: assert property (
        i_psel && i_penable && i_paddr > 8'h20 |-> o_pslverr)
        else $error("no slverr");
    a_slverr_access: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("stray slverr");
    a_unmapped_zero: assert property (
        s_rd_setup ##0 i_paddr > 8'h20 |=> o_prdata == 32'h0)
        else $error("unmapped data");
    a_prdata_hold: assert property (
        $changed(o_prdata) |-> $past(i_psel) && !$past(i_penable))
        else $error("prdata moved");
    a_rdata_upper: assert property (o_prdata[31:8] == 24'h0) else $error("upper bits");
    a_tx_pullup: assert property (o_tx_pullup_off == o_tx_oe) else $error("pullup");
    a_rxoe_pullup: assert property (o_rxtx_oe |-> o_rxtx_pullup_off)
        else $error("pullup");
    a_start_len: assert property ($fell(o_tx_pin) |-> !o_tx_pin [*8])
        else $error("short start");
    a_wake_line: assert property (o_wake |-> !$past(i_rxtx_pin, 2))
        else $error("wake");
endmodule

// ---- uasw_peer.sv ----
`timescale 1ns/100ps
module uasw_peer (
    // clock
    input wire logic i_clk,
    // serial line into the port
    output logic o_line
);
    // ==========
    // line idles high and stands still between frames
    initial o_line = 1'b1;
    task automatic hold(input logic v);
        o_line <= v;
        repeat (16) @(posedge i_clk);
    endtask
    // start low, bits lsb first, one high stop
    task automatic send(input logic [9:0] bits, input int n);
        int i;
        @(posedge i_clk);
        hold(1'b0);
        for (i = 0; i < n; i++) hold(bits[i]);
        hold(1'b1);
    endtask
endmodule

// ---- uasw_top_tb.sv ----
`timescale 1ns/100ps
module uasw_top_tb import uasw_pkg::*;;
    logic i_clk, i_reset_n, psel, pen, pwr, line, pready, slverr, txp, err;
    logic rxp, rxoe, txoe, irq;
    logic [7:0] paddr, d;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] pt;
    int err_count, samples_checked;
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    uasw_top u_dut(.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_pslverr(slverr), .o_prdata(prdata), .i_rxtx_pin(line), .o_rxtx_pin(rxp),
        .o_rxtx_oe(rxoe), .o_rxtx_pullup_off(), .o_tx_pin(txp), .o_tx_oe(txoe),
        .o_tx_pullup_off(), .o_irq(irq), .o_wake());
    uasw_peer u_peer(.i_clk(i_clk), .o_line(line));
    // ==========
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge i_clk);
        pen <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = slverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic txchk(input logic [7:0] v, input logic p);
        int i;
        do @(posedge i_clk); while (txp !== 1'b0);
        repeat (8) @(posedge i_clk);
        chk(txp, 32'h0);
        for (i = 0; i < 10; i++) begin
            repeat (16) @(posedge i_clk);
            chk(txp, i < 8 ? v[i] : (i == 8 ? p : 1'b1));
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #800000;
        err_count++;
        print_verdict();
    end
    // ==========
    // tests
    initial begin
        {i_reset_n, psel, pen, pwr, paddr, pwdata, err_count, samples_checked} = '0;
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rdchk(UASW_OFF_STATUS, 32'h0b);
        apb(1'b0, 8'h24, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        apb(1'b1, UASW_OFF_BDH, 32'h0);
        apb(1'b1, UASW_OFF_BDL, 32'h0);
        apb(1'b1, UASW_OFF_CTRL1, 32'h80);
        apb(1'b1, UASW_OFF_CTRL2, 32'hc8);
        rdchk(UASW_OFF_STATUS, 32'h0b);
        for (pt = 0; pt < 4; pt++) begin
            d = 8'h96 ^ pt;
            apb(1'b1, UASW_OFF_CTRL1, 32'ha0 | (pt << 3));
            apb(1'b1, UASW_OFF_DATA, d);
            txchk(d, pt == 0 ? ^d : (pt == 1 ? ~^d : pt == 2));
        end
        chk({irq, rxoe, txoe}, 32'h1);
        u_peer.send(10'h03c, 9);
        rdchk(UASW_OFF_STATUS, 32'h0f);
        rdchk(UASW_OFF_DATA, 32'h3c);
        u_peer.send(10'h13c, 9);
        rdchk(UASW_OFF_STATUS, 32'h8f);
        rdchk(UASW_OFF_DATA, 32'h3c);
        rdchk(UASW_OFF_STATUS, 32'h0b);
        u_peer.send(10'h03c, 9);
        rdchk(UASW_OFF_CNT, 32'h1);
        apb(1'b1, UASW_OFF_CTRL1, 32'h0);
        rdchk(UASW_OFF_CNT, 32'h0);
        rdchk(UASW_OFF_CTRL2, 32'h08);
        chk({rxoe, txoe}, 32'h0);
        apb(1'b1, UASW_OFF_CTRL1, 32'h80);
        apb(1'b1, UASW_OFF_CTRL2, 32'h81);
        apb(1'b1, UASW_OFF_CTRL3, 32'h3);
        apb(1'b1, UASW_OFF_DATA, 32'h5a);
        txchk(8'h5a, 1'b1);
        chk({irq, rxoe, txoe, rxp}, 32'hf);
        print_verdict();
    end
endmodule
bind uasw_top uasw_checker u_chk(.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rxtx_pin(i_rxtx_pin),
    .o_rxtx_oe(o_rxtx_oe), .o_rxtx_pullup_off(o_rxtx_pullup_off), .o_tx_pin(o_tx_pin),
    .o_tx_oe(o_tx_oe), .o_tx_pullup_off(o_tx_pullup_off), .o_wake(o_wake));
